// ### rtl/orr_params.svh
// Constants for the OR / return / rotate execution block.
// Assumes an 8-bit data path and a small hardware return stack.
`ifndef ORR_PARAMS_SVH
`define ORR_PARAMS_SVH
`define ORR_PC_W 12
`define ORR_SP_W 3
`define ORR_STACK_DEPTH 8
`define ORR_SP_ONE 3'h1
`define ORR_SP_RST 3'h0
`define ORR_PC_RST 12'h000
`define ORR_INT_VECTOR 12'h004
`define ORR_WREG_RST 8'h00
`define ORR_ZERO_RST 1'b0
`define ORR_MIE_RST 1'b0
`endif

// ### rtl/orr_pkg.sv
// Types and shared helpers for the OR / return / rotate block.
// Assumes nothing beyond an 8-bit data path.
`default_nettype none
package orr_pkg;
  // Instruction selector presented with each request
  typedef enum logic [2:0] {
    OP_NONE, OP_OR_IMM, OP_OR_MEM, OP_RET,
    OP_RET_IMM, OP_INTERRUPT_RETURN, OP_RL_MEM, OP_RL_WREG
  } orr_op_t;
  // Sequencer states
  typedef enum logic {ST_RUN, ST_IRQ_CHECK} orr_state_t;
  // Rotate left by one, bit 7 wraps into bit 0
  function automatic logic [7:0] rotl(input logic [7:0] v);
    rotl = {v[6:0], v[7]};
  endfunction
  // Zero detect for the zero flag
  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction
endpackage
`default_nettype wire

// ### rtl/orr_alu_if.sv
// Interface between the sequencer and its result datapath.
// Assumes both ends share core_clk.
`timescale 1ns/100ps
`default_nettype none
interface orr_alu_if;
  orr_pkg::orr_op_t op; // Instruction being executed
  logic [7:0] wreg; // Working register value
  logic [7:0] imm; // Immediate operand
  logic [7:0] mem; // Addressed data memory byte
  logic [7:0] res; // Result byte
  logic wr_wreg; // Result goes to the working register
  logic wr_mem; // Result goes to data memory
  logic wr_zero; // Zero flag follows the result
  modport alu (input op, wreg, imm, mem,
    output res, wr_wreg, wr_mem, wr_zero);
  modport core (output op, wreg, imm, mem,
    input res, wr_wreg, wr_mem, wr_zero);
endinterface
`default_nettype wire

// ### rtl/orr_alu.sv
// Result datapath: computes the byte and where it goes.
// Assumes the sequencer supplies operands in the request cycle.
`timescale 1ns/100ps
`default_nettype none
module orr_alu (
  orr_alu_if.alu a
);
  // Pure combinational decode of result and destinations
  always_comb
  begin
    a.res = 8'h00;
    a.wr_wreg = 1'b0;
    a.wr_mem = 1'b0;
    a.wr_zero = 1'b0;
    case (a.op)
      orr_pkg::OP_OR_IMM:
      begin
        a.res = a.wreg | a.imm;
        a.wr_wreg = 1'b1;
        a.wr_zero = 1'b1;
      end
      orr_pkg::OP_OR_MEM:
      begin
        a.res = a.wreg | a.mem;
        a.wr_mem = 1'b1;
        a.wr_zero = 1'b1;
      end
      orr_pkg::OP_RET_IMM:
      begin
        // Flags untouched, only the register loads
        a.res = a.imm;
        a.wr_wreg = 1'b1;
      end
      orr_pkg::OP_RL_MEM:
      begin
        a.res = orr_pkg::rotl(a.mem);
        a.wr_mem = 1'b1;
      end
      orr_pkg::OP_RL_WREG:
      begin
        a.res = orr_pkg::rotl(a.mem);
        a.wr_wreg = 1'b1;
      end
      default:
      begin
        a.res = 8'h00;
      end
    endcase
  end
endmodule // orr_alu
`default_nettype wire

// ### rtl/orr_exec.sv
// Execution unit for OR, subroutine/interrupt return and rotate left.
// Assumes data memory reads arrive combinationally with the request,
// and that irq_pending comes from logic on core_clk.
`timescale 1ns/100ps
`default_nettype none
`include "orr_params.svh"
// How it works
// - OR immediate into wreg, zero only
// - OR wreg into memory byte, zero only
// - Plain return pops PC, flags kept
// - Return pops PC and loads immediate
// - Interrupt return pops PC, enables interrupts
// - Pending interrupt serviced before resuming
// - Rotate memory left, no flags touched
// - Rotate into wreg, memory unchanged
module orr_exec (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic op_valid,
  input wire orr_pkg::orr_op_t op_code,
  input wire logic [7:0] op_imm,
  input wire logic [7:0] op_addr,
  input wire logic [7:0] mem_rd_data,
  input wire logic call_push,
  input wire logic [`ORR_PC_W-1:0] call_ret_pc,
  input wire logic irq_pending,
  output logic op_ready,
  output logic [7:0] working_register,
  output logic zero_flag,
  output logic master_interrupt_enable,
  output logic [`ORR_PC_W-1:0] fetch_pc,
  output logic fetch_load,
  output logic irq_ack,
  output logic mem_wr_en,
  output logic [7:0] mem_wr_addr,
  output logic [7:0] mem_wr_data
);
  orr_alu_if ai (); // Link to the result datapath
  orr_pkg::orr_state_t state_ff, nxt_state; // Sequencer state
  logic [7:0] wreg_ff, nxt_wreg; // Working register
  logic zero_ff, nxt_zero; // Zero flag
  logic mie_ff, nxt_mie; // Master interrupt enable
  logic [`ORR_PC_W-1:0] pc_ff, nxt_pc; // Fetch address
  logic pc_load_ff, nxt_pc_load; // Fetch redirect pulse
  logic ack_ff, nxt_ack; // Interrupt taken pulse
  logic mwe_ff, nxt_mwe; // Memory write strobe
  logic [7:0] mwa_ff, nxt_mwa; // Memory write address
  logic [7:0] mwd_ff, nxt_mwd; // Memory write data
  logic [`ORR_SP_W-1:0] sp_ff, nxt_sp; // Stack pointer, next free
  // Return stack; wraps on overflow like a small MCU stack
  logic [`ORR_PC_W-1:0] stack_ff [`ORR_STACK_DEPTH];
  logic stk_we; // Stack write enable
  logic [`ORR_SP_W-1:0] stk_wa; // Stack write slot
  logic [`ORR_PC_W-1:0] stk_wd; // Stack write value
  logic [`ORR_PC_W-1:0] stack_top; // Entry a pop would return
  logic take; // Request accepted this cycle

  orr_alu u_alu (
    .a(ai)
  );

  // Operands handed to the datapath
  assign ai.op = op_code;
  assign ai.wreg = wreg_ff;
  assign ai.imm = op_imm;
  assign ai.mem = mem_rd_data;
  assign stack_top = stack_ff[sp_ff - `ORR_SP_ONE];
  // Stalled while the post-return interrupt check runs
  assign op_ready = (state_ff == orr_pkg::ST_RUN);
  assign take = op_valid && op_ready;

  // Next-state logic for the whole sequencer
  always_comb
  begin
    nxt_state = state_ff;
    nxt_wreg = wreg_ff;
    nxt_zero = zero_ff;
    nxt_mie = mie_ff;
    nxt_pc = pc_ff;
    nxt_sp = sp_ff;
    nxt_pc_load = 1'b0;
    nxt_ack = 1'b0;
    nxt_mwe = 1'b0;
    nxt_mwa = mwa_ff;
    nxt_mwd = mwd_ff;
    stk_we = 1'b0;
    stk_wa = sp_ff;
    stk_wd = call_ret_pc;
    case (state_ff)
      orr_pkg::ST_RUN:
      begin
        if (take)
        begin
          // Destination steering from the datapath
          if (ai.wr_wreg)
          begin
            nxt_wreg = ai.res;
          end
          if (ai.wr_mem)
          begin
            nxt_mwe = 1'b1;
            nxt_mwa = op_addr;
            nxt_mwd = ai.res;
          end
          if (ai.wr_zero)
          begin
            nxt_zero = orr_pkg::is_zero(ai.res);
          end
          // All three returns pop; none touch the zero flag, and interrupt return sets the master interrupt enable
          if (op_code == orr_pkg::OP_RET ||
              op_code == orr_pkg::OP_RET_IMM ||
              op_code == orr_pkg::OP_INTERRUPT_RETURN)
          begin
            nxt_sp = sp_ff - `ORR_SP_ONE;
            nxt_pc = stack_top;
            nxt_pc_load = 1'b1;
          end
          if (op_code == orr_pkg::OP_INTERRUPT_RETURN)
          begin
            nxt_mie = 1'b1;
            nxt_state = orr_pkg::ST_IRQ_CHECK;
          end
        end
        else if (call_push)
        begin
          // Calls come from outside; any request taken in the same cycle wins
          stk_we = 1'b1;
          nxt_sp = sp_ff + `ORR_SP_ONE;
        end
      end
      orr_pkg::ST_IRQ_CHECK:
      begin
        nxt_state = orr_pkg::ST_RUN;
        // A waiting interrupt goes first; the popped PC is pushed
        // back so its routine returns to the main program.
        if (irq_pending && mie_ff)
        begin
          stk_we = 1'b1;
          stk_wd = pc_ff;
          nxt_sp = sp_ff + `ORR_SP_ONE;
          nxt_pc = `ORR_INT_VECTOR;
          nxt_pc_load = 1'b1;
          nxt_mie = 1'b0;
          nxt_ack = 1'b1;
        end
      end
      default:
      begin
        nxt_state = orr_pkg::ST_RUN;
      end
    endcase
  end

  // State registers; clk_en low freezes everything
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= orr_pkg::ST_RUN;
      wreg_ff <= `ORR_WREG_RST;
      zero_ff <= `ORR_ZERO_RST;
      mie_ff <= `ORR_MIE_RST;
      pc_ff <= `ORR_PC_RST;
      sp_ff <= `ORR_SP_RST;
      pc_load_ff <= 1'b0;
      ack_ff <= 1'b0;
      mwe_ff <= 1'b0;
      mwa_ff <= 8'h00;
      mwd_ff <= 8'h00;
    end
    else if (clk_en)
    begin
      state_ff <= nxt_state;
      wreg_ff <= nxt_wreg;
      zero_ff <= nxt_zero;
      mie_ff <= nxt_mie;
      pc_ff <= nxt_pc;
      sp_ff <= nxt_sp;
      pc_load_ff <= nxt_pc_load;
      ack_ff <= nxt_ack;
      mwe_ff <= nxt_mwe;
      mwa_ff <= nxt_mwa;
      mwd_ff <= nxt_mwd;
    end
  end

  // Stack storage, written one slot at a time
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < `ORR_STACK_DEPTH; i++)
      begin
        stack_ff[i] <= `ORR_PC_RST;
      end
    end
    else if (clk_en && stk_we)
    begin
      stack_ff[stk_wa] <= stk_wd;
    end
  end

  // Outputs straight from flip-flops
  assign working_register = wreg_ff;
  assign zero_flag = zero_ff;
  assign master_interrupt_enable = mie_ff;
  assign fetch_pc = pc_ff;
  assign fetch_load = pc_load_ff;
  assign irq_ack = ack_ff;
  assign mem_wr_en = mwe_ff;
  assign mem_wr_addr = mwa_ff;
  assign mem_wr_data = mwd_ff;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  or_imm_a: assert property (
    clk_en && take && op_code == orr_pkg::OP_OR_IMM |=>
    wreg_ff == ($past(wreg_ff) | $past(op_imm)) && !mwe_ff)
    else $error("OR immediate wrong");
  or_mem_a: assert property (
    clk_en && take && op_code == orr_pkg::OP_OR_MEM |=>
    mwe_ff && mwa_ff == $past(op_addr) &&
    mwd_ff == ($past(wreg_ff) | $past(mem_rd_data)) &&
    wreg_ff == $past(wreg_ff))
    else $error("OR to memory wrong");
  ret_pop_a: assert property (
    clk_en && take && op_code == orr_pkg::OP_RET |=>
    pc_load_ff && pc_ff == $past(stack_top) &&
    zero_ff == $past(zero_ff))
    else $error("Return pop wrong");
  ret_imm_a: assert property (
    clk_en && take && op_code == orr_pkg::OP_RET_IMM |=>
    pc_load_ff && wreg_ff == $past(op_imm) &&
    zero_ff == $past(zero_ff))
    else $error("Return immediate wrong");
  interrupt_return_mie_a: assert property (
    clk_en && take && op_code == orr_pkg::OP_INTERRUPT_RETURN |=>
    mie_ff && pc_ff == $past(stack_top) &&
    state_ff == orr_pkg::ST_IRQ_CHECK)
    else $error("Interrupt return wrong");
  interrupt_return_irq_a: assert property (
    clk_en && state_ff == orr_pkg::ST_IRQ_CHECK &&
    irq_pending && mie_ff |=>
    ack_ff && pc_ff == `ORR_INT_VECTOR && !mie_ff &&
    $past(pc_ff) == stack_top)
    else $error("Pending interrupt skipped");
  rl_mem_a: assert property (
    clk_en && take && op_code == orr_pkg::OP_RL_MEM |=>
    mwe_ff &&
    mwd_ff == {$past(mem_rd_data[6:0]), $past(mem_rd_data[7])} &&
    zero_ff == $past(zero_ff))
    else $error("Rotate memory wrong");
  rl_wreg_a: assert property (
    clk_en && take && op_code == orr_pkg::OP_RL_WREG |=>
    !mwe_ff &&
    wreg_ff == {$past(mem_rd_data[6:0]), $past(mem_rd_data[7])} &&
    zero_ff == $past(zero_ff))
    else $error("Rotate to wreg wrong");
  // Expected zero computed from the operands, not from the datapath
  zero_flag_a: assert property (
    clk_en && take && (op_code == orr_pkg::OP_OR_IMM ||
    op_code == orr_pkg::OP_OR_MEM) |=>
    zero_ff == (($past(wreg_ff) |
    ($past(op_code) == orr_pkg::OP_OR_IMM ?
    $past(op_imm) : $past(mem_rd_data))) == 8'h00))
    else $error("Zero flag wrong");
endmodule // orr_exec
`default_nettype wire

// ### verification/orr_exec_test.sv
// Self-checking bench for the OR / return / rotate execution unit.
// Assumes orr_pkg and orr_params.svh are compiled or on the include path.
`timescale 1ns/100ps
`default_nettype none
`include "orr_params.svh"
module orr_exec_test;
  logic core_clk; // 50 MHz core clock
  logic rst_n; // Active-low reset
  logic clk_en, op_valid, call_push, irq_pending;
  orr_pkg::orr_op_t op_code;
  logic [7:0] op_imm, op_addr, mem_rd_data;
  logic [`ORR_PC_W-1:0] call_ret_pc, fetch_pc;
  logic op_ready, zero_flag, master_interrupt_enable, fetch_load;
  logic irq_ack, mem_wr_en;
  logic [7:0] working_register, mem_wr_addr, mem_wr_data;
  int fails; // Mismatches seen
  int check_count; // Comparisons made

  orr_exec dut_u (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .op_valid(op_valid), .op_code(op_code), .op_imm(op_imm),
    .op_addr(op_addr), .mem_rd_data(mem_rd_data), .call_push(call_push),
    .call_ret_pc(call_ret_pc), .irq_pending(irq_pending),
    .op_ready(op_ready), .working_register(working_register),
    .zero_flag(zero_flag),
    .master_interrupt_enable(master_interrupt_enable),
    .fetch_pc(fetch_pc), .fetch_load(fetch_load), .irq_ack(irq_ack),
    .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data));

  // Half period of 10 ns gives the 20 ns core clock
  always #10 core_clk = ~core_clk;

  // Case equality so an unknown never passes as a match
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Single place where the run ends
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // One request; returns mid-cycle after the taking edge.
  // Waits for op_ready first, since a return from interrupt refuses one.
  task automatic do_op(input orr_pkg::orr_op_t op, input logic [7:0] imm,
                       input logic [7:0] mem);
    int n;
    n = 0;
    @(negedge core_clk);
    while (op_ready !== 1'b1 && n < 4)
    begin
      n++;
      @(negedge core_clk);
    end
    if (op_ready !== 1'b1)
    begin
      fails++;
      finish_test();
    end
    @(posedge core_clk);
    op_valid <= 1'b1;
    op_code <= op;
    op_imm <= imm;
    op_addr <= mem ^ 8'h3c;
    mem_rd_data <= mem;
    @(posedge core_clk);
    op_valid <= 1'b0;
    op_code <= orr_pkg::OP_NONE;
    // Released bus shows the inverse, not a stale copy
    mem_rd_data <= ~mem;
    @(negedge core_clk);
  endtask

  // One-cycle push of a return address onto the stack
  task automatic push(input logic [`ORR_PC_W-1:0] pc);
    @(posedge core_clk);
    call_push <= 1'b1;
    call_ret_pc <= pc;
    @(posedge core_clk);
    call_push <= 1'b0;
  endtask

  // OR immediate: zero set on a zero result from 00 OR 00
  task automatic t_or_imm();
    do_op(orr_pkg::OP_OR_IMM, 8'h00, 8'h00);
    check(16'(working_register), 16'h0000);
    check(16'(zero_flag), 16'h0001);
  endtask

  // Rotates with zero flag high: it must stay high
  task automatic t_rotate();
    do_op(orr_pkg::OP_RL_MEM, 8'h00, 8'h81);
    check(16'({mem_wr_en, mem_wr_addr}), 16'h01bd);
    check(16'(mem_wr_data), 16'h0003);
    check(16'({zero_flag, working_register}), 16'h0100);
    do_op(orr_pkg::OP_RL_WREG, 8'h00, 8'h80);
    check(16'(mem_wr_en), 16'h0000);
    check(16'({zero_flag, working_register}), 16'h0101);
  endtask

  // OR into memory after building a nonzero working register
  task automatic t_or_mem();
    do_op(orr_pkg::OP_OR_IMM, 8'h52, 8'h00);
    do_op(orr_pkg::OP_OR_IMM, 8'h08, 8'h00);
    check(16'({zero_flag, working_register}), 16'h005b);
    do_op(orr_pkg::OP_OR_MEM, 8'h00, 8'h81);
    check(16'({mem_wr_en, mem_wr_addr}), 16'h01bd);
    check(16'({mem_wr_data, working_register}), 16'hdb5b);
    check(16'(zero_flag), 16'h0000);
    @(negedge core_clk);
    check(16'(mem_wr_en), 16'h0000);
  endtask

  // Plain return and return with immediate, last in first out
  task automatic t_returns();
    push(12'h123);
    push(12'h456);
    do_op(orr_pkg::OP_RET, 8'h00, 8'h00);
    check(16'({fetch_load, fetch_pc}), 16'h1456);
    check(16'({zero_flag, working_register}), 16'h005b);
    do_op(orr_pkg::OP_RET_IMM, 8'h00, 8'h00);
    check(16'({fetch_load, fetch_pc}), 16'h1123);
    // Zero result loaded, yet the zero flag must not follow it
    check(16'({zero_flag, working_register}), 16'h0000);
  endtask

  // Interrupt return, first quiet, then with a request pending
  task automatic t_interrupt_return();
    push(12'h2ab);
    do_op(orr_pkg::OP_INTERRUPT_RETURN, 8'h00, 8'h00);
    check(16'({fetch_load, fetch_pc}), 16'h12ab);
    check(16'(master_interrupt_enable), 16'h0001);
    check(16'({op_ready, irq_ack}), 16'h0000);
    push(12'h300);
    irq_pending <= 1'b1;
    do_op(orr_pkg::OP_INTERRUPT_RETURN, 8'h00, 8'h00);
    check(16'({fetch_pc, master_interrupt_enable}), 16'h0601);
    @(posedge core_clk);
    irq_pending <= 1'b0;
    @(negedge core_clk);
    check(16'({irq_ack, fetch_load, fetch_pc}), 16'h3004);
    check(16'(master_interrupt_enable), 16'h0000);
    // The service routine returns to the interrupted address
    do_op(orr_pkg::OP_RET, 8'h00, 8'h00);
    check(16'(fetch_pc), 16'h0300);
  endtask

  // Clock enable low: a presented request must leave no trace
  task automatic t_freeze();
    @(posedge core_clk);
    clk_en <= 1'b0;
    op_valid <= 1'b1;
    op_code <= orr_pkg::OP_OR_IMM;
    op_imm <= 8'hff;
    @(posedge core_clk);
    op_valid <= 1'b0;
    clk_en <= 1'b1;
    @(negedge core_clk);
    check(16'(working_register), 16'h0000);
  endtask

  // Watchdog: a hang counts as a failure
  initial
  begin
    repeat (3000) @(posedge core_clk);
    fails++;
    finish_test();
  end

  // Main sequence
  initial
  begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    op_valid = 1'b0;
    op_code = orr_pkg::OP_NONE;
    op_imm = 8'h00;
    op_addr = 8'h00;
    mem_rd_data = 8'h00;
    call_push = 1'b0;
    call_ret_pc = 12'h000;
    irq_pending = 1'b0;
    fails = 0;
    check_count = 0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    check(16'({op_ready, master_interrupt_enable, zero_flag}), 16'h0004);
    check(16'({working_register, fetch_pc[7:0]}), 16'h0000);
    t_or_imm();
    t_rotate();
    t_or_mem();
    t_returns();
    t_freeze();
    t_interrupt_return();
    finish_test();
  end
endmodule // orr_exec_test
`default_nettype wire
